/* File: urx_error_flags.sv */
// Receive-side break, framing and parity status of a queued serial port.
// Assumes characters come from a receive shifter on ref_clk and the line pin
// is asynchronous; software uses the plain register port.
//
// Functional notes
// - Reset clears break, framing, parity flags
// - Break clears only by read-one, write-zero
// - Framing error then zero framing error sets break in async mode
// - Zero characters not queued during break
// - Queueing resumes once line returns mark
// - Framing status stored with each character in async mode
// - Framing flag high when head has error
// - Framing flag low when head error-free
// - Parity status stored with each character in async mode
// - Parity flag high when head has error
// - Parity flag low when head error-free
// - Only first stop bit decides framing
`timescale 1ns/1ps
`include "urx_params.svh"

module urx_error_flags #(
    parameter int DEPTH = `URX_QUEUE_DEPTH,
    parameter int AW = `URX_QUEUE_AW
) (
    input wire logic ref_clk,                     // 200 MHz system clock
    input wire logic rst,                         // Asynchronous reset, active high
    input wire logic rx_line,                     // Receive pin, asynchronous
    input wire logic rx_char_valid,               // One-cycle strobe from shifter
    input wire urx_pkg::urx_char_t rx_char,       // Received character and checks
    input wire logic [`URX_ADDR_W-1:0] reg_addr,  // Register byte address
    input wire logic [`URX_DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr,                      // Write strobe
    input wire logic reg_rd,                      // Read strobe
    output logic [`URX_DATA_W-1:0] reg_rdata,     // Read data, cycle after strobe
    output logic line_break_seen_flag,            // Sticky break indication
    output logic frame_fault_flag,                // Head character framing error
    output logic parity_fault_flag,               // Head character parity error
    output logic rx_async_mode                    // Asynchronous mode enable
);

    // ==========================================================
    // Line synchroniser; only the second stage is looked at
    logic line_meta_reg;
    logic line_sync_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_meta_reg <= 1'b1;
            line_sync_reg <= 1'b1;
        end else begin
            line_meta_reg <= rx_line;
            line_sync_reg <= line_meta_reg;
        end
    end

    // ==========================================================
    // State and register declarations
    urx_pkg::urx_break_state_t state_reg;
    urx_pkg::urx_break_state_t state_next;
    logic prev_frm_err_reg;
    logic break_reg;
    logic break_next;
    logic break_armed_reg;
    logic break_armed_next;
    logic frm_flag_reg;
    logic par_flag_reg;
    logic async_reg;
    logic [`URX_DATA_W-1:0] rdata_reg;
    logic [`URX_DATA_W-1:0] rdata_next;

    // Queue interface
    urx_pkg::urx_entry_t push_entry;
    urx_pkg::urx_entry_t q_head;
    logic q_empty;
    logic [AW:0] q_count;

    // ==========================================================
    // Register port decode
    wire sel_data = (reg_addr == `URX_ADDR_DATA);
    wire sel_status = (reg_addr == `URX_ADDR_STATUS);
    wire sel_ctrl = (reg_addr == `URX_ADDR_CTRL);
    wire sel_count = (reg_addr == `URX_ADDR_COUNT);
    wire wr_status = reg_wr && sel_status;
    wire wr_ctrl = reg_wr && sel_ctrl;
    wire rd_status = reg_rd && sel_status;
    // Reading the queue port pops; an empty queue is not popped
    wire pop_w = reg_rd && sel_data && !q_empty;

    // ==========================================================
    // Character classification
    // A second stop bit is never looked at, so a glitch there is harmless
    wire frame_err_w = !rx_char.stop1;
    wire space_char_w = (rx_char.data == `URX_SPACE_CHAR);
    // Second framing error in a row on an all-space character marks a break
    wire break_cond_w = rx_char_valid && async_reg && frame_err_w && prev_frm_err_reg
        && space_char_w;
    // Nothing is queued while the break lasts, nor the detecting character
    wire push_w = rx_char_valid && (state_reg == urx_pkg::URX_RECV)
        && !break_cond_w;

    // Error status is only kept in asynchronous mode
    assign push_entry.data = rx_char.data;
    assign push_entry.frm_err = async_reg && frame_err_w;
    assign push_entry.par_err = async_reg && rx_char.parity_err;

    // ==========================================================
    // Receive queue
    urx_rx_queue #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_queue (
        .ref_clk(ref_clk),
        .rst(rst),
        .push(push_w),
        .push_entry(push_entry),
        .pop(pop_w),
        .head(q_head),
        .empty(q_empty),
        .full(),
        .count(q_count)
    );

    // ==========================================================
    // Break state: suppress until the line is back at mark
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            urx_pkg::URX_RECV: begin
                if (break_cond_w) begin
                    state_next = urx_pkg::URX_SUPPRESS;
                end
            end
            urx_pkg::URX_SUPPRESS: begin
                // A further all-space character with a framing error after a framing error means the break still lasts
                if (line_sync_reg && !break_cond_w) begin
                    state_next = urx_pkg::URX_RECV;
                end
            end
            default: begin
                state_next = urx_pkg::URX_RECV;
            end
        endcase
    end

    // ==========================================================
    // Break flag: armed by a read of one, cleared by a later write of zero
    wire clear_break_w = wr_status && !reg_wdata[`URX_BIT_BREAK] && break_armed_reg;

    // Set wins over a clear in the same cycle, so no break is lost
    always_comb begin
        break_next = break_reg;
        if (break_cond_w) begin
            break_next = 1'b1;
        end else if (clear_break_w) begin
            break_next = 1'b0;
        end
    end

    // Any status write consumes the arming; a fresh read is needed each time
    always_comb begin
        break_armed_next = break_armed_reg;
        if (wr_status) begin
            break_armed_next = 1'b0;
        end else if (rd_status && break_reg) begin
            break_armed_next = 1'b1;
        end
    end

    // ==========================================================
    // Read data mux
    always_comb begin
        rdata_next = `URX_WORD_ZERO;
        if (sel_data) begin
            rdata_next[`URX_CHAR_W-1:0] = q_empty ? `URX_SPACE_CHAR : q_head.data;
        end else if (sel_status) begin
            rdata_next[`URX_BIT_BREAK] = break_reg;
            rdata_next[`URX_BIT_FRAME] = frm_flag_reg;
            rdata_next[`URX_BIT_PARITY] = par_flag_reg;
        end else if (sel_ctrl) begin
            rdata_next[`URX_BIT_ASYNC] = async_reg;
        end else if (sel_count) begin
            rdata_next[AW:0] = q_count;
        end
    end

    // ==========================================================
    // State, break and control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= urx_pkg::URX_RECV;
            prev_frm_err_reg <= 1'b0;
            break_reg <= 1'b0;
            break_armed_reg <= 1'b0;
            async_reg <= `URX_CTRL_RST;
        end else begin
            state_reg <= state_next;
            break_reg <= break_next;
            break_armed_reg <= break_armed_next;
            if (rx_char_valid) begin
                prev_frm_err_reg <= frame_err_w;
            end
            if (wr_ctrl) begin
                async_reg <= reg_wdata[`URX_BIT_ASYNC];
            end
        end
    end

    // Head error flags follow the queue; status writes never touch them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frm_flag_reg <= 1'b0;
            par_flag_reg <= 1'b0;
        end else begin
            frm_flag_reg <= !q_empty && q_head.frm_err;
            par_flag_reg <= !q_empty && q_head.par_err;
        end
    end

    // Read data is held only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= `URX_WORD_ZERO;
        end else begin
            rdata_reg <= reg_rd ? rdata_next : `URX_WORD_ZERO;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = rdata_reg;
    assign line_break_seen_flag = break_reg;
    assign frame_fault_flag = frm_flag_reg;
    assign parity_fault_flag = par_flag_reg;
    assign rx_async_mode = async_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Reset itself must be watched, so the default disable is overridden here
    property p_reset_clear;
        @(posedge ref_clk) disable iff (1'b0)
            rst |-> !break_reg && !frm_flag_reg && !par_flag_reg;
    endproperty
    chk_reset_clears_flags: assert property (p_reset_clear)
        else $error("Flags not zero during reset");

    chk_break_clear_cause: assert property (
        $fell(break_reg) |-> $past(wr_status) && $past(break_armed_reg)
            && !$past(reg_wdata[`URX_BIT_BREAK]))
        else $error("Break flag cleared without read-one write-zero");

    chk_break_unarmed_hold: assert property (
        break_reg && wr_status && !break_armed_reg |=> break_reg)
        else $error("Break flag cleared without prior read");

    chk_break_set_cause: assert property (
        rx_char_valid && async_reg && !rx_char.stop1 && prev_frm_err_reg
            && rx_char.data == `URX_SPACE_CHAR |=> break_reg && state_reg == urx_pkg::URX_SUPPRESS)
        else $error("Break not flagged after second space framing error");

    chk_break_no_push: assert property (
        rx_char_valid && state_reg == urx_pkg::URX_SUPPRESS
            |=> q_count == $past(q_count) - (AW+1)'($past(pop_w)))
        else $error("Character queued during break");

    chk_resume_on_mark: assert property (
        state_reg == urx_pkg::URX_SUPPRESS && line_sync_reg && !break_cond_w
            |=> state_reg == urx_pkg::URX_RECV)
        else $error("Reception did not resume at mark");

    chk_frame_follows_head: assert property (
        !q_empty && q_head.frm_err |=> frm_flag_reg)
        else $error("Framing flag low for faulty head");

    chk_frame_clears_auto: assert property (
        q_empty || !q_head.frm_err |=> !frm_flag_reg)
        else $error("Framing flag high for clean head");

    chk_parity_follows_head: assert property (
        !q_empty && q_head.par_err |=> par_flag_reg)
        else $error("Parity flag low for faulty head");

    chk_parity_clears_auto: assert property (
        q_empty || !q_head.par_err |=> !par_flag_reg)
        else $error("Parity flag high for clean head");

    chk_first_stop_only: assert property (
        push_w |-> push_entry.frm_err == (async_reg && !rx_char.stop1))
        else $error("Framing status not from first stop bit");

    chk_break_sticky: assert property (
        break_reg && !clear_break_w |=> break_reg)
        else $error("Break flag dropped without software clear");

    cov_break_seen: cover property (break_cond_w ##[1:200] line_sync_reg);
    cov_break_cleared: cover property (rd_status && break_reg ##[1:20] clear_break_w);
    cov_frame_head: cover property (frm_flag_reg && pop_w);
    cov_resume_push: cover property (state_reg == urx_pkg::URX_SUPPRESS ##1
        state_reg == urx_pkg::URX_RECV ##[1:100] push_w);

endmodule

/* File: urx_params.svh */
// Constants of the receive error and break status block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef URX_PARAMS_SVH
`define URX_PARAMS_SVH

// ==========================================================
// Register map (byte addresses on the plain register port)
`define URX_ADDR_W 4
`define URX_ADDR_DATA 4'h0
`define URX_ADDR_STATUS 4'h4
`define URX_ADDR_CTRL 4'h8
`define URX_ADDR_COUNT 4'hC

// ==========================================================
// Field positions and widths
`define URX_DATA_W 32
`define URX_CHAR_W 8
`define URX_BIT_BREAK 4
`define URX_BIT_FRAME 3
`define URX_BIT_PARITY 2
`define URX_BIT_ASYNC 0

// ==========================================================
// Reset values and constants
`define URX_CTRL_RST 1'b1
`define URX_SPACE_CHAR 8'h00
`define URX_WORD_ZERO 32'h0000_0000
`define URX_QUEUE_DEPTH 16
`define URX_QUEUE_AW 4

`endif

/* File: urx_pkg.sv */
// Types shared by the receive queue and the error and break status block.
// Assumes urx_params.svh is on the include path.
`include "urx_params.svh"

package urx_pkg;

    // ==========================================================
    // Character handed over by the receive shifter
    typedef struct packed {
        logic [`URX_CHAR_W-1:0] data;
        logic stop1;      // First stop bit as sampled
        logic stop2;      // Second stop bit, only meaningful in two stop bit mode
        logic parity_err; // Parity check failed
    } urx_char_t;

    // ==========================================================
    // One receive queue entry: character plus its error status
    typedef struct packed {
        logic par_err; // Parity check failed on this character
        logic frm_err; // First stop bit was missing
        logic [`URX_CHAR_W-1:0] data;
    } urx_entry_t;

    // ==========================================================
    // Break handling states
    typedef enum logic {
        URX_RECV,
        URX_SUPPRESS
    } urx_break_state_t;

endpackage

/* File: urx_rx_queue.sv */
// Receive queue: stores characters together with their error status.
// Assumes one clock, push and pop from logic on the same clock.
`timescale 1ns/1ps
`include "urx_params.svh"

module urx_rx_queue #(
    parameter int DEPTH = `URX_QUEUE_DEPTH,
    parameter int AW = `URX_QUEUE_AW
) (
    input wire logic ref_clk,                  // System clock
    input wire logic rst,                      // Asynchronous reset, active high
    input wire logic push,                     // Write one entry
    input wire urx_pkg::urx_entry_t push_entry, // Entry to write
    input wire logic pop,                      // Remove the head entry
    output urx_pkg::urx_entry_t head,          // Entry that will be read next
    output logic empty,                        // No entry stored
    output logic full,                         // No room left
    output logic [AW:0] count                  // Number of stored entries
);

    // ==========================================================
    // Storage; error bits travel with each character
    urx_pkg::urx_entry_t mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    // Status decoded from the fill count
    assign count = count_reg;
    assign empty = (count_reg == '0);
    assign full = (count_reg == (AW+1)'(DEPTH));
    assign head = mem[rd_ptr_reg];

    // Entry write; a push while full is dropped rather than overwriting
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_entry;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

endmodule

/* File: urx_remote_tx.sv */
// Behavioural model of the remote serial transmitter that feeds the block.
// Assumes one clock, ref_clk; whole characters arrive already deserialised.
`timescale 1ns/1ps

module urx_remote_tx (
    input wire logic ref_clk,          // System clock
    output logic rx_line,              // Line level, mark when idle
    output logic rx_char_valid,        // One-cycle character strobe
    output urx_pkg::urx_char_t rx_char // Character and its check results
);
    // ==========================================================
    // Idle line at mark, no strobe
    initial begin
        rx_line = 1'b1;
        rx_char_valid = 1'b0;
        rx_char = '0;
    end

    // ==========================================================
    // Line level; held at space for as long as a break lasts
    task automatic set_line(input logic lvl);
        @(posedge ref_clk);
        rx_line <= lvl;
    endtask

    // One character; the fields change outside the strobe, so nothing
    // downstream may lean on stale values
    task automatic send(input logic [7:0] d, input logic s1, input logic s2, input logic pe);
        @(posedge ref_clk);
        rx_char_valid <= 1'b1;
        rx_char <= {d, s1, s2, pe};
        @(posedge ref_clk);
        rx_char_valid <= 1'b0;
        rx_char <= ~rx_char;
    endtask
endmodule

/* File: uart_rx_error_flags_tb.sv */
// Self-checking bench for the receive error and break status block.
// Assumes the remote transmitter model and the design on one 200 MHz clock.
`timescale 1ns/1ps
`include "urx_params.svh"

module uart_rx_error_flags_tb;
    logic ref_clk;
    logic rst;
    logic rx_line;
    logic rx_char_valid;
    urx_pkg::urx_char_t rx_char;
    logic [`URX_ADDR_W-1:0] reg_addr;
    logic [`URX_DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [`URX_DATA_W-1:0] reg_rdata;
    logic line_break_seen_flag;
    logic frame_fault_flag;
    logic parity_fault_flag;
    logic rx_async_mode;
    urx_pkg::urx_entry_t exp_q[$];
    int n_errors = 0;
    int compares = 0;

    // ==========================================================
    // Clock, far side and design
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    urx_remote_tx tx_u (.ref_clk(ref_clk), .rx_line(rx_line), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char));

    urx_error_flags dut_u (.ref_clk(ref_clk), .rst(rst), .rx_line(rx_line),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_break_seen_flag(line_break_seen_flag), .frame_fault_flag(frame_fault_flag),
        .parity_fault_flag(parity_fault_flag), .rx_async_mode(rx_async_mode));

    // ==========================================================
    // Expectations: sync mode stores no error status
    function automatic urx_pkg::urx_entry_t entry_of(input logic [7:0] d, input logic s1,
        input logic pe, input logic m);
        return {pe & m, ~s1 & m, d};
    endfunction

    function automatic logic [31:0] exp_status(input logic exp_break);
        logic [31:0] w;
        w = `URX_WORD_ZERO;
        w[`URX_BIT_BREAK] = exp_break;
        if (exp_q.size() != 0) begin
            w[`URX_BIT_FRAME] = exp_q[0].frm_err;
            w[`URX_BIT_PARITY] = exp_q[0].par_err;
        end
        return w;
    endfunction

    // ==========================================================
    // Comparison, bus cycles and closing
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data are only valid in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Flags trail the queue head by one cycle, so let four pass
    task automatic check_head(input logic exp_break);
        logic [31:0] d;
        logic [31:0] st;
        repeat (4) @(posedge ref_clk);
        st = exp_status(exp_break);
        #1 chk_flag("frame flag", st[`URX_BIT_FRAME], frame_fault_flag);
        chk_flag("parity flag", st[`URX_BIT_PARITY], parity_fault_flag);
        chk_flag("break flag", exp_break, line_break_seen_flag);
        reg_read(`URX_ADDR_STATUS, d);
        chk_word("status", st, d);
        reg_read(`URX_ADDR_COUNT, d);
        chk_word("count", 32'(exp_q.size()), d);
    endtask

    // Reads every queued character back, head flags checked after each pop
    task automatic drain(input logic exp_break);
        logic [31:0] d;
        while (exp_q.size() != 0) begin
            reg_read(`URX_ADDR_DATA, d);
            chk_word("data", {24'b0, exp_q[0].data}, d);
            void'(exp_q.pop_front());
            check_head(exp_break);
        end
        reg_read(`URX_ADDR_DATA, d);
        chk_word("empty data", `URX_WORD_ZERO, d);
    endtask

    // ==========================================================
    // Watchdog against a hang anywhere in the sequence
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("wrong value run length expected finish seen timeout");
        stop_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [7:0] c;
        logic s1;
        logic p;
        d = $urandom(32'h0b93);
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        check_head(1'b0);
        chk_flag("async mode", 1'b1, rx_async_mode);
        reg_read(`URX_ADDR_CTRL, d);
        chk_word("ctrl reset", 32'h0000_0001, d);
        reg_read(4'h2, d);
        chk_word("unmapped", `URX_WORD_ZERO, d);
        // Random characters in sync mode, then async; first has a bad second stop
        for (int m = 0; m < 2; m++) begin
            reg_write(`URX_ADDR_CTRL, 32'(m));
            #1 chk_flag("async mode", 1'(m), rx_async_mode);
            for (int i = 0; i < 6; i++) begin
                c = 8'($urandom_range(1, 255));
                s1 = (i == 0) ? 1'b1 : 1'($urandom);
                p = 1'($urandom);
                tx_u.send(c, s1, (i == 0) ? 1'b0 : 1'($urandom), p);
                exp_q.push_back(entry_of(c, s1, p, 1'(m)));
            end
            check_head(1'b0);
            reg_write(`URX_ADDR_STATUS, 32'h0000_000c);
            check_head(1'b0);
            drain(1'b0);
        end
        // Framing fault, then zero characters with line at space
        tx_u.send(8'h55, 1'b0, 1'b1, 1'b0);
        exp_q.push_back(entry_of(8'h55, 1'b0, 1'b0, 1'b1));
        tx_u.set_line(1'b0);
        repeat (3) tx_u.send(`URX_SPACE_CHAR, 1'b0, 1'b0, 1'b0);
        check_head(1'b1);
        // Line back at mark: queueing resumes, break stays
        tx_u.set_line(1'b1);
        repeat (4) @(posedge ref_clk);
        tx_u.send(8'h3c, 1'b1, 1'b1, 1'b1);
        exp_q.push_back(entry_of(8'h3c, 1'b1, 1'b1, 1'b1));
        check_head(1'b1);
        // Each check reads status and so arms the clear; a write of one
        // disarms it, so the following write of zero must not clear
        reg_write(`URX_ADDR_STATUS, 32'h0000_0010);
        reg_write(`URX_ADDR_STATUS, `URX_WORD_ZERO);
        check_head(1'b1);
        // A write of one while armed never clears
        reg_write(`URX_ADDR_STATUS, 32'h0000_0010);
        check_head(1'b1);
        reg_read(`URX_ADDR_STATUS, d);
        reg_write(`URX_ADDR_STATUS, `URX_WORD_ZERO);
        check_head(1'b0);
        drain(1'b0);
        // Reset in mid-run with break, framing and parity flags all set
        tx_u.send(8'h55, 1'b0, 1'b1, 1'b1);
        exp_q.push_back(entry_of(8'h55, 1'b0, 1'b1, 1'b1));
        tx_u.send(`URX_SPACE_CHAR, 1'b0, 1'b0, 1'b0);
        check_head(1'b1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        exp_q.delete();
        check_head(1'b0);
        stop_test();
    end
endmodule
